/* design/socket_power_irq_ctrl.sv */
// Purpose: Socket power control and interrupt/general control registers
// Assumes: Byte register port on i_clk_sys; card pins are asynchronous
// Notes: Power register layout follows the compatibility revision field
//
// How it works
// - Power bit 7 drives o_card_output_gate only; o_card_reset is not gated by it; zero after reset means disabled.
// - Standard layout: power bits 6, 3 and 2 read zero, not writable.
// - Standard layout: bit 5 enables card-detect auto power switching, if system allows.
// - Standard layout: bit 4 enables Vcc at system-chosen level, Vpp from field.
// - Vpp field: 00 none, 01 equals Vcc, 10 twelve volts, 11 reserved.
// - Vpp request ignored unless socket Vcc is on at 5 V or 3.3 V.
// - Extended layout: bits 4:3 request Vcc: 00/01 off, 10 5 V, 11 3.3 V.
// - Extended layout: bits 6, 5, 2 read zero; bits 7 and 1:0 unchanged.
// - Revision field resets to 0100; writing 0010 selects standard layout.
// - Status bit 6 shows whether socket Vcc is on at 5 V or 3.3 V; Vpp does not enter it.
// - Control bit 7 enables ring indicate on the battery-detect input.
// - Control bit 6 low holds 16-bit card reset; high releases it.
// - Control bit 5 records card kind: 0 memory, 1 I/O.
// - Control bit 4 routes status-change interrupts to PCI, else by config field.
// - Select field 0000: no functional routing; status-change forced to PCI.
// - Nonzero select: line by number, 0010 means SYSTEM_MANAGEMENT_INTERRUPT instead.
`timescale 1ns/100ps
module socket_power_irq_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Register port
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rd_valid,
  // System control register bits, same clock
  input wire logic i_auto_switch_allow,
  input wire logic i_vcc_level_select,
  // Card-side pins
  input wire logic i_card_detect1_n,
  input wire logic i_card_detect2_n,
  input wire logic i_battery_detect_ring_input,
  input wire logic i_card_func_irq,
  // Socket state from the surrounding controller
  input wire logic i_card_is_16bit,
  input wire logic i_csc_event,
  // Card side and power switch
  output logic o_card_output_gate,
  output logic o_card_reset,
  output logic o_ring_indicate,
  output logic o_vcc_5v_en,
  output logic o_vcc_3v3_en,
  output logic o_vpp_vcc_en,
  output logic o_vpp_12v_en,
  // Interrupt routing
  output logic [15:0] o_func_irq_lines,
  output logic o_func_smi,
  output logic [15:0] o_csc_irq_lines,
  output logic o_csc_smi,
  output logic o_csc_pci
);

  // Register storage
  logic [3:0] compat_revision_field;
  logic [1:0] id_spare;
  logic [7:0] power_reg;
  logic [7:0] irq_general;
  logic [7:0] csc_config;

  // Synchronised pins
  logic cd1_n;
  logic cd2_n;
  logic batt_ring;
  logic card_irq;

  pin_sync2 #(
    .WIDTH(4),
    .RST_VAL(4'hF)
  ) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async({i_card_detect1_n, i_card_detect2_n, i_battery_detect_ring_input, i_card_func_irq}),
    .o_sync({cd1_n, cd2_n, batt_ring, card_irq})
  );

  // Layout selection
  wire std_layout = (compat_revision_field == socket_ctrl_pkg::COMPAT_STD_CODE);
  wire [7:0] power_wmask = std_layout ? socket_ctrl_pkg::PWR_MASK_STD
                                      : socket_ctrl_pkg::PWR_MASK_EXT;

  // Decoded power fields
  wire card_output_gate = power_reg[socket_ctrl_pkg::PWR_OUT_GATE_BIT];
  wire auto_socket_power_switch = power_reg[socket_ctrl_pkg::PWR_AUTO_SW_BIT];
  wire socket_supply_enable = power_reg[socket_ctrl_pkg::PWR_SUPPLY_EN_BIT];
  wire [1:0] vcc_request_field = power_reg[socket_ctrl_pkg::PWR_VCC_LSB +: 2];
  wire [1:0] vpp_request_field = power_reg[socket_ctrl_pkg::PWR_VPP_LSB +: 2];
  wire card_present = !cd1_n && !cd2_n;

  // Auto switching only counts when system control lets it
  wire auto_active = auto_socket_power_switch && i_auto_switch_allow;
  wire std_vcc_on = socket_supply_enable && (!auto_active || card_present);
  wire next_vcc_5v = std_layout ? (std_vcc_on && !i_vcc_level_select)
                                : (vcc_request_field == socket_ctrl_pkg::VCC_5V);
  wire next_vcc_3v3 = std_layout ? (std_vcc_on && i_vcc_level_select)
                                 : (vcc_request_field == socket_ctrl_pkg::VCC_3V3);
  wire vcc_on = next_vcc_5v || next_vcc_3v3;
  // Vpp follows the field only while Vcc is up; reserved code gives nothing
  wire next_vpp_vcc = vcc_on && (vpp_request_field == socket_ctrl_pkg::VPP_EQ_VCC);
  wire next_vpp_12v = vcc_on && (vpp_request_field == socket_ctrl_pkg::VPP_12V);
  wire socket_powered_flag = vcc_on;

  // Decoded control fields
  wire ring_indicate_enable = irq_general[socket_ctrl_pkg::IGC_RING_BIT];
  wire card_reset_release = irq_general[socket_ctrl_pkg::IGC_RESET_BIT];
  wire card_kind = irq_general[socket_ctrl_pkg::IGC_KIND_BIT];
  wire status_change_pci_route = irq_general[socket_ctrl_pkg::IGC_CSC_PCI_BIT];
  wire [3:0] functional_irq_select = irq_general[socket_ctrl_pkg::IGC_SEL_LSB +: 4];
  wire [3:0] status_change_line_select = csc_config[socket_ctrl_pkg::CSC_SEL_LSB +: 4];

  // Select 0000 forces status change to PCI as well
  wire csc_to_pci = status_change_pci_route
                    || (functional_irq_select == socket_ctrl_pkg::ROUTE_NONE);
  // Functional interrupts only exist for an I/O card
  wire func_event = card_kind && !card_irq;
  // Card reset only touches 16-bit cards
  wire next_card_reset = i_card_is_16bit && !card_reset_release;
  // Ring indicate shares the battery-detect pin of an I/O card
  wire next_ring = ring_indicate_enable && card_kind && !batt_ring;

  // One address match shared by the write strobes and the read mux
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return (addr == ofs);
  endfunction

  wire hit_id = reg_hit(i_reg_addr, socket_ctrl_pkg::OFS_ID_REVISION);
  wire hit_status = reg_hit(i_reg_addr, socket_ctrl_pkg::OFS_IF_STATUS);
  wire hit_power = reg_hit(i_reg_addr, socket_ctrl_pkg::OFS_POWER);
  wire hit_igc = reg_hit(i_reg_addr, socket_ctrl_pkg::OFS_IRQ_GENERAL);
  wire hit_csc = reg_hit(i_reg_addr, socket_ctrl_pkg::OFS_CSC_CONFIG);

  // Register write decode; the status byte has no write path
  wire wr_id = i_reg_wr_en && hit_id;
  wire wr_power = i_reg_wr_en && hit_power;
  wire wr_igc = i_reg_wr_en && hit_igc;
  wire wr_csc = i_reg_wr_en && hit_csc;

  // Read views; reserved power bits read zero in either layout
  wire [7:0] id_view = {socket_ctrl_pkg::ID_IF_TYPE, id_spare, compat_revision_field};
  wire [7:0] status_view = {1'b0, socket_powered_flag, 2'b00, !cd2_n, !cd1_n, 2'b00};
  wire [7:0] power_view = power_reg & power_wmask;
  wire [7:0] read_mux =
    hit_id ? id_view :
    hit_status ? status_view :
    hit_power ? power_view :
    hit_igc ? irq_general :
    hit_csc ? csc_config : 8'h00;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      compat_revision_field <= socket_ctrl_pkg::RST_COMPAT_REVISION;
      id_spare <= socket_ctrl_pkg::RST_ID_SPARE;
    end else if (wr_id) begin
      compat_revision_field <= i_reg_wdata[3:0];
      id_spare <= i_reg_wdata[5:4];
    end
  end

  // Reserved bits are dropped at write time under the current layout
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      power_reg <= socket_ctrl_pkg::RST_POWER;
    end else if (wr_power) begin
      power_reg <= i_reg_wdata & power_wmask;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      irq_general <= socket_ctrl_pkg::RST_IRQ_GENERAL;
      csc_config <= socket_ctrl_pkg::RST_CSC_CONFIG;
    end else begin
      if (wr_igc) begin
        irq_general <= i_reg_wdata;
      end
      if (wr_csc) begin
        csc_config <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
      o_reg_rd_valid <= 1'b0;
    end else begin
      o_reg_rd_valid <= i_reg_rd_en;
      o_reg_rdata <= i_reg_rd_en ? read_mux : 8'h00;
    end
  end

  // Card side and power switch drive, registered
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_card_output_gate <= 1'b0;
      o_card_reset <= 1'b0;
      o_ring_indicate <= 1'b0;
      o_vcc_5v_en <= 1'b0;
      o_vcc_3v3_en <= 1'b0;
      o_vpp_vcc_en <= 1'b0;
      o_vpp_12v_en <= 1'b0;
    end else begin
      o_card_output_gate <= card_output_gate;
      o_card_reset <= next_card_reset;
      o_ring_indicate <= next_ring;
      o_vcc_5v_en <= next_vcc_5v;
      o_vcc_3v3_en <= next_vcc_3v3;
      o_vpp_vcc_en <= next_vpp_vcc;
      o_vpp_12v_en <= next_vpp_12v;
    end
  end

  // Functional interrupt never goes to PCI here
  irq_line_router u_func_router (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_event(func_event),
    .i_select(functional_irq_select),
    .i_to_pci(1'b0),
    .o_lines(o_func_irq_lines),
    .o_smi(o_func_smi),
    .o_pci()
  );

  irq_line_router u_csc_router (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_event(i_csc_event),
    .i_select(status_change_line_select),
    .i_to_pci(csc_to_pci),
    .o_lines(o_csc_irq_lines),
    .o_smi(o_csc_smi),
    .o_pci(o_csc_pci)
  );

endmodule // socket_power_irq_ctrl

/* design/socket_ctrl_pkg.sv */
// Purpose: Shared constants for the socket power and interrupt control bank
// Assumes: Byte-wide register port, one 200 MHz clock
// Notes: Offsets are byte offsets of the socket register window
package socket_ctrl_pkg;

  // Register offsets
  localparam logic [7:0] OFS_ID_REVISION = 8'h00;
  localparam logic [7:0] OFS_IF_STATUS = 8'h01;
  localparam logic [7:0] OFS_POWER = 8'h02;
  localparam logic [7:0] OFS_IRQ_GENERAL = 8'h03;
  localparam logic [7:0] OFS_CSC_CONFIG = 8'h05;

  // Reset values
  localparam logic [3:0] RST_COMPAT_REVISION = 4'h4;
  localparam logic [1:0] RST_ID_SPARE = 2'h0;
  localparam logic [7:0] RST_POWER = 8'h00;
  localparam logic [7:0] RST_IRQ_GENERAL = 8'h00;
  localparam logic [7:0] RST_CSC_CONFIG = 8'h00;

  // Identification register: hardwired interface type in bits 7:6
  localparam logic [1:0] ID_IF_TYPE = 2'h2;
  // Revision code that selects the standard-compatible power layout
  localparam logic [3:0] COMPAT_STD_CODE = 4'h2;

  // Power register fields
  localparam int PWR_OUT_GATE_BIT = 7;
  localparam int PWR_AUTO_SW_BIT = 5;
  localparam int PWR_SUPPLY_EN_BIT = 4;
  localparam int PWR_VCC_LSB = 3;
  localparam int PWR_VPP_LSB = 0;
  // Writable bits per layout
  localparam logic [7:0] PWR_MASK_STD = 8'hB3;
  localparam logic [7:0] PWR_MASK_EXT = 8'h9B;

  // Vcc request field codes, extended layout
  localparam logic [1:0] VCC_OFF = 2'h0;
  localparam logic [1:0] VCC_OFF_RSVD = 2'h1;
  localparam logic [1:0] VCC_5V = 2'h2;
  localparam logic [1:0] VCC_3V3 = 2'h3;

  // Vpp request field codes
  localparam logic [1:0] VPP_NONE = 2'h0;
  localparam logic [1:0] VPP_EQ_VCC = 2'h1;
  localparam logic [1:0] VPP_12V = 2'h2;
  localparam logic [1:0] VPP_RSVD = 2'h3;

  // Interrupt and general control fields
  localparam int IGC_RING_BIT = 7;
  localparam int IGC_RESET_BIT = 6;
  localparam int IGC_KIND_BIT = 5;
  localparam int IGC_CSC_PCI_BIT = 4;
  localparam int IGC_SEL_LSB = 0;
  localparam int CSC_SEL_LSB = 4;

  // Routing codes
  localparam logic [3:0] ROUTE_NONE = 4'h0;
  localparam logic [3:0] ROUTE_SMI = 4'h2;

  // Interface status bit positions
  localparam int STAT_POWERED_BIT = 6;
  localparam int STAT_CD2_BIT = 3;
  localparam int STAT_CD1_BIT = 2;

endpackage

/* design/pin_sync2.sv */
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to i_clk_sys
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module pin_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // pin_sync2

/* design/irq_line_router.sv */
// Purpose: Steer one interrupt event to a legacy line, SYSTEM_MANAGEMENT_INTERRUPT or PCI
// Assumes: Event is synchronous to i_clk_sys
// Notes: Outputs are registered, one cycle after the event
`timescale 1ns/100ps
module irq_line_router (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_event,
  input wire logic [3:0] i_select,
  input wire logic i_to_pci,
  output logic [15:0] o_lines,
  output logic o_smi,
  output logic o_pci
);
  // Code 0 and the SYSTEM_MANAGEMENT_INTERRUPT code never drive a numbered line
  wire legacy_ok = !i_to_pci && (i_select != socket_ctrl_pkg::ROUTE_NONE)
                   && (i_select != socket_ctrl_pkg::ROUTE_SMI);
  wire [15:0] one_hot = 16'h0001 << i_select;
  wire [15:0] next_lines = (i_event && legacy_ok) ? one_hot : 16'h0000;
  wire next_smi = i_event && !i_to_pci && (i_select == socket_ctrl_pkg::ROUTE_SMI);
  wire next_pci = i_event && i_to_pci;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_lines <= 16'h0000;
      o_smi <= 1'b0;
      o_pci <= 1'b0;
    end else begin
      o_lines <= next_lines;
      o_smi <= next_smi;
      o_pci <= next_pci;
    end
  end
endmodule // irq_line_router

/* test/socket_ctrl_assertions.sv */
// Purpose: Port-level checks for the socket power and interrupt control bank
// Assumes: One clock domain, asynchronous active-high reset
// Notes: Sees only the top module's ports
`timescale 1ns/100ps
module socket_ctrl_assertions (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rd_valid,
  input wire logic i_card_is_16bit,
  input wire logic o_card_output_gate,
  input wire logic o_card_reset,
  input wire logic o_vcc_5v_en,
  input wire logic o_vcc_3v3_en,
  input wire logic o_vpp_vcc_en,
  input wire logic o_vpp_12v_en,
  input wire logic [15:0] o_func_irq_lines,
  input wire logic o_func_smi,
  input wire logic [15:0] o_csc_irq_lines,
  input wire logic o_csc_smi,
  input wire logic o_csc_pci
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire logic pwr_wr = i_reg_wr_en && i_reg_addr == socket_ctrl_pkg::OFS_POWER;
  wire logic igc_wr = i_reg_wr_en && i_reg_addr == socket_ctrl_pkg::OFS_IRQ_GENERAL;
  wire logic pwr_rd = i_reg_rd_en && i_reg_addr == socket_ctrl_pkg::OFS_POWER;
  wire logic wd_gate = i_reg_wdata[7];
  wire logic wd_release = i_reg_wdata[6];

  AST_RD_VALID: assert property (i_reg_rd_en |=> o_reg_rd_valid)
    else $error("read strobe not answered");
  AST_OUT_GATE: assert property (pwr_wr ##1 !pwr_wr |=> o_card_output_gate == $past(wd_gate, 2))
    else $error("output gate does not follow power bit 7");
  AST_PWR_RSVD: assert property (pwr_rd |=> o_reg_rdata[6] == 1'b0 && o_reg_rdata[2] == 1'b0)
    else $error("reserved power bit reads one");
  AST_VCC_EXCL: assert property (!(o_vcc_5v_en && o_vcc_3v3_en))
    else $error("both Vcc levels on");
  AST_VPP_CODE: assert property (!(o_vpp_vcc_en && o_vpp_12v_en))
    else $error("both Vpp levels on");
  AST_VPP_NEEDS_VCC: assert property ((o_vpp_vcc_en || o_vpp_12v_en) |-> (o_vcc_5v_en || o_vcc_3v3_en))
    else $error("Vpp on without Vcc");
  AST_CARD_RESET: assert property (igc_wr ##1 !igc_wr |=>
    o_card_reset == ($past(i_card_is_16bit) && !$past(wd_release, 2)))
    else $error("card reset does not follow control bit 6");
  AST_FUNC_LINES: assert property ($onehot0(o_func_irq_lines) && !o_func_irq_lines[0] && !o_func_irq_lines[2])
    else $error("bad functional line pattern");
  AST_SMI_EXCL: assert property (o_func_smi |-> o_func_irq_lines == 16'h0000)
    else $error("SYSTEM_MANAGEMENT_INTERRUPT and legacy line together");
  AST_CSC_PCI: assert property (o_csc_pci |-> o_csc_irq_lines == 16'h0000 && !o_csc_smi)
    else $error("status change routed twice");
  COV_SMI: cover property (o_func_smi);
  COV_PCI: cover property (o_csc_pci);
  COV_12V: cover property (o_vpp_12v_en);
  COV_CSC_SMI: cover property (o_csc_smi);
endmodule // socket_ctrl_assertions

/* test/card_socket_model.sv */
// Purpose: Behavioural 16-bit card and socket power switch
// Assumes: Every card pin has a pull-up on the socket side
// Notes: Absent card leaves all pins to the pull-ups; unpowered card its ring and interrupt pins
`timescale 1ns/100ps
module card_socket_model (
  input wire logic i_present,
  input wire logic i_ring,
  input wire logic i_irq,
  input wire logic i_vcc_5v_en,
  input wire logic i_vcc_3v3_en,
  output logic o_detect1_n,
  output logic o_detect2_n,
  output logic o_ring_in_n,
  output logic o_func_irq_n
);
  wire logic powered = i_present && (i_vcc_5v_en || i_vcc_3v3_en);
  // Detect pins are grounded in the card, need no power
  assign o_detect1_n = !i_present;
  assign o_detect2_n = !i_present;
  assign o_ring_in_n = !(powered && i_ring);
  assign o_func_irq_n = !(powered && i_irq);
endmodule // card_socket_model

/* test/tb_top.sv */
// Purpose: Self-checking bench for the socket power and interrupt control bank
// Assumes: 200 MHz clock, reset held 8 cycles
// Notes: Pin inputs need three cycles, so checks wait five
`timescale 1ns/100ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0, rd_en = 1'b0, allow = 1'b0, lvl = 1'b0, present = 1'b0, ring = 1'b0, irq = 1'b0;
  logic is16 = 1'b0, csc = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got;
  logic rd_valid, gate, card_rst, ring_ind, v5, v3, vppv, v12, fsmi, csmi, cpci, cd1_n, cd2_n, ri_n, firq_n;
  logic [15:0] flines, clines;
  int err_total = 0, n_checks = 0;

  socket_power_irq_ctrl u_socket_power_irq_ctrl (.i_clk_sys(clk_sys), .i_rst(rst), .i_reg_wr_en(wr_en),
    .i_reg_rd_en(rd_en), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rd_valid(rd_valid),
    .i_auto_switch_allow(allow), .i_vcc_level_select(lvl), .i_card_detect1_n(cd1_n), .i_card_detect2_n(cd2_n),
    .i_battery_detect_ring_input(ri_n), .i_card_func_irq(firq_n), .i_card_is_16bit(is16), .i_csc_event(csc),
    .o_card_output_gate(gate), .o_card_reset(card_rst), .o_ring_indicate(ring_ind), .o_vcc_5v_en(v5),
    .o_vcc_3v3_en(v3), .o_vpp_vcc_en(vppv), .o_vpp_12v_en(v12), .o_func_irq_lines(flines), .o_func_smi(fsmi),
    .o_csc_irq_lines(clines), .o_csc_smi(csmi), .o_csc_pci(cpci));
  card_socket_model u_card_socket_model (.i_present(present), .i_ring(ring), .i_irq(irq), .i_vcc_5v_en(v5),
    .i_vcc_3v3_en(v3), .o_detect1_n(cd1_n), .o_detect2_n(cd2_n), .o_ring_in_n(ri_n), .o_func_irq_n(firq_n));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(16'(rd_valid), 16'h0001);
    got = rdata;
  endtask

  // Covers register latency plus the pin synchroniser
  task automatic settle;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_reset;
    logic [7:0] ofs [5] = '{8'h00, 8'h02, 8'h03, 8'h05, 8'h10};
    logic [7:0] exp [5] = '{8'h84, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 5; k++) begin
      rd(ofs[k]);
      chk(16'(got), 16'(exp[k]));
    end
    chk(16'(gate), 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_ext_power;
    logic [1:0] vcc, vpp;
    logic on;
    wr(8'h02, 8'hFF);
    rd(8'h02);
    chk(16'(got), 16'h009B);
    for (int k = 0; k < 16; k++) begin
      vcc = 2'(k >> 2);
      vpp = 2'(k);
      on = vcc[1];
      wr(8'h02, {3'b100, vcc, 1'b0, vpp});
      settle();
      chk({11'h000, gate, v5, v3, vppv, v12}, {11'h000, 1'b1, vcc == 2'h2, vcc == 2'h3, on && vpp == 2'h1,
        on && vpp == 2'h2});
      rd(8'h01);
      chk(16'(got & 8'h40), 16'({1'b0, on, 6'h00}));
    end
    $display("test extended power done");
  endtask

  task automatic t_std_power;
    wr(8'h00, 8'h02);
    wr(8'h02, 8'hFF);
    rd(8'h02);
    chk(16'(got), 16'h00B3);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      lvl <= k[0];
      wr(8'h02, 8'h90);
      wr(8'h02, 8'h91);
      settle();
      chk({12'h000, v5, v3, vppv, v12}, {12'h000, !k[0], k[0], 2'b10});
    end
    wr(8'h02, 8'h81);
    settle();
    chk({12'h000, v5, v3, vppv, v12}, 16'h0000);
    @(posedge clk_sys);
    allow <= 1'b1;
    wr(8'h02, 8'hB0);
    settle();
    chk(16'(v3), 16'h0000);
    @(posedge clk_sys);
    present <= 1'b1;
    settle();
    chk(16'(v3), 16'h0001);
    wr(8'h00, 8'h04);
    rd(8'h02);
    chk(16'(got), 16'h0090);
    $display("test standard power done");
  endtask

  task automatic t_irq;
    wr(8'h02, 8'h90);
    @(posedge clk_sys);
    is16 <= 1'b1;
    irq <= 1'b1;
    ring <= 1'b1;
    csc <= 1'b1;
    wr(8'h05, 8'h30);
    wr(8'h03, 8'hA0);
    settle();
    chk({14'h0000, card_rst, ring_ind}, 16'h0003);
    wr(8'h03, 8'h60);
    settle();
    chk({14'h0000, card_rst, ring_ind}, 16'h0000);
    for (int k = 0; k < 16; k++) begin
      wr(8'h03, 8'(8'h20 + k));
      settle();
      chk(flines, (k == 0 || k == 2) ? 16'h0000 : 16'(1 << k));
      chk({13'h0000, fsmi, csmi, cpci}, {13'h0000, k == 2, 1'b0, k == 0});
      chk(clines, (k == 0) ? 16'h0000 : 16'h0008);
    end
    wr(8'h05, 8'h20);
    settle();
    chk({13'h0000, fsmi, csmi, cpci}, 16'h0002);
    chk(clines, 16'h0000);
    wr(8'h03, 8'h13);
    settle();
    chk(flines, 16'h0000);
    chk({15'h0000, cpci}, 16'h0001);
    @(posedge clk_sys);
    is16 <= 1'b0;
    settle();
    chk(16'(card_rst), 16'h0000);
    $display("test interrupt control done");
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_ext_power();
    t_std_power();
    t_irq();
    conclude();
  end

  // Whole run needs a few microseconds
  initial begin
    #100000;
    err_total++;
    conclude();
  end
endmodule // tb_top

bind socket_power_irq_ctrl socket_ctrl_assertions u_socket_ctrl_assertions (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_reg_wr_en(i_reg_wr_en), .i_reg_rd_en(i_reg_rd_en), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .o_reg_rd_valid(o_reg_rd_valid), .i_card_is_16bit(i_card_is_16bit),
  .o_card_output_gate(o_card_output_gate), .o_card_reset(o_card_reset), .o_vcc_5v_en(o_vcc_5v_en),
  .o_vcc_3v3_en(o_vcc_3v3_en), .o_vpp_vcc_en(o_vpp_vcc_en), .o_vpp_12v_en(o_vpp_12v_en),
  .o_func_irq_lines(o_func_irq_lines), .o_func_smi(o_func_smi), .o_csc_irq_lines(o_csc_irq_lines),
  .o_csc_smi(o_csc_smi), .o_csc_pci(o_csc_pci));
